/* pkg/playback_pkg.sv */
package playback_pkg;
	// register byte addresses
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] COUNT_ADDR = 8'h04;
	localparam logic [7:0] LOAD_ADDR_ADDR = 8'h08;
	localparam logic [7:0] LOAD_DATA_ADDR = 8'h0C;
	localparam logic [7:0] LEVEL_ADDR = 8'h10;
	localparam logic [7:0] LOSS_ADDR = 8'h14;
	localparam logic [7:0] STATUS_ADDR = 8'h18;
	localparam logic [7:0] IRQ_STAT_ADDR = 8'h1C;
	localparam logic [7:0] IRQ_MASK_ADDR = 8'h20;
	// control fields
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_RATE_LSB = 1;
	localparam int RATE_W = 2;
	// sample and memory geometry
	localparam int CODE_W = 14;
	localparam logic [15:0] CODE_MAX = 16'h3FFF;
	localparam int ADDR_W = 24;
	localparam int CNT_W = 25;
	localparam logic [CNT_W-1:0] CNT_MAX = 25'h1000000;
	localparam int DEPTH = 16777216;
	// interrupt event bits
	localparam int IRQ_W = 3;
	localparam int EV_RANGE = 0;
	localparam int EV_OVLD = 1;
	localparam int EV_WRAP = 2;
	// sample rates, with step counts in half-megahertz units of the system clock
	typedef enum logic [1:0] {RATE_32M, RATE_12M5, RATE_100M, RATE_BAD} rate_t;
	localparam longint CLK_HZ = 200000000;
	localparam longint UNIT_HZ = 500000;
	localparam longint RATE32_HZ = 32000000;
	localparam longint RATE12M5_HZ = 12500000;
	localparam longint RATE100_HZ = 100000000;
	localparam logic [8:0] PHASE_TOP = 9'(CLK_HZ / UNIT_HZ);
	localparam logic [8:0] STEP_32M = 9'(RATE32_HZ / UNIT_HZ);
	localparam logic [8:0] STEP_12M5 = 9'(RATE12M5_HZ / UNIT_HZ);
	localparam logic [8:0] STEP_100M = 9'(RATE100_HZ / UNIT_HZ);
	// overload limit on level plus loss, tenths of a dB
	localparam logic [16:0] OVLD_LIMIT_DEF = 17'h00190;
endpackage

/* rtl/looped_waveform_playback.sv */
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
//
// Operation
// RQ1: play stored samples in order, loop forever
// RQ2: rate is 32, 12.5 or 100 MHz
// RQ3: output codes are 14-bit, 0 to 16383
// RQ4: offset binary, zero is minus full scale
// RQ5: sample count configurable up to 16M
// RQ6: run until stopped; rate, set frozen
// RQ7: one new code per sample period
// RQ8: out-of-range sample rejects set, flags error
// RQ9: overload settings flag warning, refuse play
// RQ10: loader keeps mean near 8191.5
// RQ11: loader gives noise at least 2M samples
// RQ12: address starts zero, wraps, halts on stop
module looped_waveform_playback #(
	parameter logic [16:0] OVLD_LIMIT = playback_pkg::OVLD_LIMIT_DEF
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic [playback_pkg::CODE_W-1:0] dac_code_o,
	output logic dac_strobe_o,
	output logic running_o,
	output logic irq_o
);
	logic [playback_pkg::CODE_W-1:0] mem [0:playback_pkg::DEPTH-1];
	logic running_r;
	logic [playback_pkg::RATE_W-1:0] rate_r;
	logic [playback_pkg::CNT_W-1:0] count_r;
	logic [playback_pkg::ADDR_W-1:0] load_addr_r;
	logic [playback_pkg::ADDR_W-1:0] rd_addr_r;
	logic [15:0] level_r;
	logic [15:0] loss_r;
	logic set_bad_r;
	logic [8:0] phase_r;
	logic [8:0] phase_nxt;
	logic [playback_pkg::IRQ_W-1:0] irq_stat_r;
	logic [playback_pkg::IRQ_W-1:0] irq_mask_r;
	logic [31:0] prdata_r;
	logic [playback_pkg::CODE_W-1:0] dac_code_r;
	logic strobe_r;

	// address match helper, used by every register decode
	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		return a == r;
	endfunction

	// apb decode: zero wait states, errors on unmapped addresses
	wire setup = psel_i & ~penable_i;
	wire wr = psel_i & penable_i & pwrite_i;
	wire mapped = hit(paddr_i, playback_pkg::CTRL_ADDR) | hit(paddr_i, playback_pkg::COUNT_ADDR)
		| hit(paddr_i, playback_pkg::LOAD_ADDR_ADDR) | hit(paddr_i, playback_pkg::LOAD_DATA_ADDR)
		| hit(paddr_i, playback_pkg::LEVEL_ADDR) | hit(paddr_i, playback_pkg::LOSS_ADDR)
		| hit(paddr_i, playback_pkg::STATUS_ADDR) | hit(paddr_i, playback_pkg::IRQ_STAT_ADDR)
		| hit(paddr_i, playback_pkg::IRQ_MASK_ADDR);
	wire wr_ctrl = wr & hit(paddr_i, playback_pkg::CTRL_ADDR);
	wire wr_count = wr & hit(paddr_i, playback_pkg::COUNT_ADDR);
	wire wr_laddr = wr & hit(paddr_i, playback_pkg::LOAD_ADDR_ADDR);
	wire wr_ldata = wr & hit(paddr_i, playback_pkg::LOAD_DATA_ADDR);
	wire wr_level = wr & hit(paddr_i, playback_pkg::LEVEL_ADDR);
	wire wr_loss = wr & hit(paddr_i, playback_pkg::LOSS_ADDR);
	wire wr_istat = wr & hit(paddr_i, playback_pkg::IRQ_STAT_ADDR);
	wire wr_imask = wr & hit(paddr_i, playback_pkg::IRQ_MASK_ADDR);

	// start and stop requests from the run bit
	wire run_bit = pwdata_i[playback_pkg::CTRL_RUN_BIT];
	wire [playback_pkg::RATE_W-1:0] rate_wd =
		pwdata_i[playback_pkg::CTRL_RATE_LSB +: playback_pkg::RATE_W];
	wire start_req = wr_ctrl & run_bit & ~running_r;
	wire stop_req = wr_ctrl & ~run_bit & running_r;
	// overload is judged on the summed level and loss at start time
	wire [16:0] ovld_sum = {1'b0, level_r} + {1'b0, loss_r};
	wire overload = ovld_sum > OVLD_LIMIT; // RQ9
	wire start_rate_ok = rate_wd != playback_pkg::RATE_BAD; // RQ2
	wire start_ok = start_req & ~set_bad_r & ~overload & start_rate_ok
		& (count_r != '0); // RQ8 RQ9
	wire load_bad = wr_ldata & ~running_r & (pwdata_i[15:0] > playback_pkg::CODE_MAX)
		& (pwdata_i[31:16] == '0); // RQ8
	wire load_bad_hi = wr_ldata & ~running_r & (pwdata_i[31:16] != '0);
	wire range_ev = load_bad | load_bad_hi; // RQ8
	wire ovld_ev = start_req & overload; // RQ9

	// sample clock: fractional phase in half-megahertz units, exact for all three rates
	wire [8:0] step = (rate_r == playback_pkg::RATE_12M5) ? playback_pkg::STEP_12M5 :
		(rate_r == playback_pkg::RATE_100M) ? playback_pkg::STEP_100M :
		playback_pkg::STEP_32M; // RQ2
	wire [8:0] phase_sum = phase_r + step;
	wire tick = running_r & (phase_sum >= playback_pkg::PHASE_TOP); // RQ7
	assign phase_nxt = tick ? 9'(phase_sum - playback_pkg::PHASE_TOP) : phase_sum;
	wire last = {1'b0, rd_addr_r} == 25'(count_r - 25'h0000001); // RQ12
	wire wrap_ev = tick & last; // RQ1

	// control registers; rate, count and memory are frozen while playing
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			running_r <= 1'b0;
			rate_r <= playback_pkg::RATE_32M;
			count_r <= '0;
			level_r <= '0;
			loss_r <= '0;
		end else begin
			if (start_ok) begin
				running_r <= 1'b1; // RQ6
				rate_r <= rate_wd; // RQ6
			end else if (stop_req) begin
				running_r <= 1'b0; // RQ6
			end
			if (wr_count & ~running_r & (pwdata_i[24:0] <= playback_pkg::CNT_MAX)) begin
				count_r <= pwdata_i[24:0]; // RQ5
			end
			if (wr_level) begin
				level_r <= pwdata_i[15:0];
			end
			if (wr_loss) begin
				loss_r <= pwdata_i[15:0];
			end
		end
	end

	// loader side: a new count starts a new set and forgets an earlier rejection
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			load_addr_r <= '0;
			set_bad_r <= 1'b0;
		end else begin
			if (range_ev) begin
				set_bad_r <= 1'b1; // RQ8
			end else if (wr_count & ~running_r) begin
				set_bad_r <= 1'b0;
			end
			if (wr_laddr & ~running_r) begin
				load_addr_r <= pwdata_i[playback_pkg::ADDR_W-1:0];
			end else if (wr_ldata & ~running_r) begin
				load_addr_r <= load_addr_r + 24'h000001;
			end
		end
	end

	// sample memory; only in-range codes are stored, offset binary as given
	always_ff @(posedge clk_i) begin
		if (wr_ldata & ~running_r & ~range_ev) begin
			mem[load_addr_r] <= pwdata_i[playback_pkg::CODE_W-1:0]; // RQ3 RQ4
		end
	end

	// read-out: address restarts on start, wraps after the last sample
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rd_addr_r <= '0;
			phase_r <= '0;
			strobe_r <= 1'b0;
		end else begin
			strobe_r <= tick; // RQ7
			if (start_ok) begin
				rd_addr_r <= '0; // RQ12
				phase_r <= '0;
			end else if (tick) begin
				rd_addr_r <= last ? '0 : rd_addr_r + 24'h000001; // RQ1 RQ12
				phase_r <= phase_nxt;
			end else if (running_r) begin
				phase_r <= phase_nxt;
			end
		end
	end

	// converter code holds its last value when stopped; memory is not reset
	always_ff @(posedge clk_i) begin
		if (tick) begin
			dac_code_r <= mem[rd_addr_r]; // RQ1 RQ3
		end
	end

	// sticky events: a new event wins over a write-one clear in the same cycle
	wire [playback_pkg::IRQ_W-1:0] ev = {wrap_ev, ovld_ev, range_ev};
	wire [playback_pkg::IRQ_W-1:0] clr = wr_istat ? pwdata_i[playback_pkg::IRQ_W-1:0] : '0;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq_stat_r <= '0;
			irq_mask_r <= '0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~clr) | ev;
			if (wr_imask) begin
				irq_mask_r <= pwdata_i[playback_pkg::IRQ_W-1:0];
			end
		end
	end

	// read data is captured in the setup cycle so it leaves a flip-flop
	wire [31:0] rdata =
		hit(paddr_i, playback_pkg::CTRL_ADDR) ? {29'h0, rate_r, running_r} :
		hit(paddr_i, playback_pkg::COUNT_ADDR) ? {7'h0, count_r} :
		hit(paddr_i, playback_pkg::LOAD_ADDR_ADDR) ? {8'h0, load_addr_r} :
		hit(paddr_i, playback_pkg::LEVEL_ADDR) ? {16'h0, level_r} :
		hit(paddr_i, playback_pkg::LOSS_ADDR) ? {16'h0, loss_r} :
		hit(paddr_i, playback_pkg::STATUS_ADDR) ? {29'h0, overload, set_bad_r, running_r} :
		hit(paddr_i, playback_pkg::IRQ_STAT_ADDR) ? {29'h0, irq_stat_r} :
		hit(paddr_i, playback_pkg::IRQ_MASK_ADDR) ? {29'h0, irq_mask_r} : 32'h0;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			prdata_r <= '0;
		end else if (setup) begin
			prdata_r <= rdata;
		end
	end

	assign prdata_o = prdata_r;
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~mapped;
	assign dac_code_o = dac_code_r;
	assign dac_strobe_o = strobe_r;
	assign running_o = running_r;
	assign irq_o = |(irq_stat_r & irq_mask_r);

	// checks
	sequence s_gap1;
		~tick ##1 tick;
	endsequence
	property p_wrap;
		@(posedge clk_i) disable iff (!nrst_i) wrap_ev & ~stop_req |=> rd_addr_r == '0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("read address did not wrap"); // RQ12
	property p_step;
		@(posedge clk_i) disable iff (!nrst_i) tick & ~last |=> rd_addr_r == $past(rd_addr_r) + 24'h000001;
	endproperty
	a_step: assert property (p_step) else $error("read address skipped"); // RQ1
	property p_rate100;
		@(posedge clk_i) disable iff (!nrst_i)
			tick & (rate_r == playback_pkg::RATE_100M) & ~stop_req ##1 ~stop_req |-> s_gap1;
	endproperty
	a_rate100: assert property (p_rate100) else $error("100 MHz spacing wrong"); // RQ2
	property p_strobe;
		@(posedge clk_i) disable iff (!nrst_i) $changed(dac_code_o) |-> dac_strobe_o;
	endproperty
	a_strobe: assert property (p_strobe) else $error("code changed without strobe"); // RQ7
	property p_reject;
		@(posedge clk_i) disable iff (!nrst_i) load_bad |=> set_bad_r ##1 set_bad_r | ~running_r;
	endproperty
	a_reject: assert property (p_reject) else $error("bad sample not flagged"); // RQ8
	property p_norun_bad;
		@(posedge clk_i) disable iff (!nrst_i) start_req & set_bad_r |=> ~running_r;
	endproperty
	a_norun_bad: assert property (p_norun_bad) else $error("rejected set played"); // RQ8
	property p_ovld;
		@(posedge clk_i) disable iff (!nrst_i)
			start_req & overload |=> ~running_r & irq_stat_r[playback_pkg::EV_OVLD];
	endproperty
	a_ovld: assert property (p_ovld) else $error("overload start not refused"); // RQ9
	property p_frozen;
		@(posedge clk_i) disable iff (!nrst_i) running_r & ~stop_req |=> $stable(rate_r) & $stable(count_r);
	endproperty
	a_frozen: assert property (p_frozen) else $error("rate or count changed in play"); // RQ6
	property p_start;
		@(posedge clk_i) disable iff (!nrst_i) start_ok |=> running_r & rd_addr_r == '0 & phase_r == '0;
	endproperty
	a_start: assert property (p_start) else $error("start did not clear address"); // RQ12
	property p_count;
		@(posedge clk_i) disable iff (!nrst_i) count_r <= playback_pkg::CNT_MAX;
	endproperty
	a_count: assert property (p_count) else $error("count above maximum"); // RQ5
	property p_stop;
		@(posedge clk_i) disable iff (!nrst_i) stop_req |=> ~running_r ##1 ~dac_strobe_o;
	endproperty
	a_stop: assert property (p_stop) else $error("strobe after stop"); // RQ12
	property p_range_hi;
		@(posedge clk_i) disable iff (!nrst_i) load_bad_hi |=> set_bad_r & irq_stat_r[playback_pkg::EV_RANGE];
	endproperty
	a_range_hi: assert property (p_range_hi) else $error("wide sample not rejected"); // RQ8
	property p_wrap_irq;
		@(posedge clk_i) disable iff (!nrst_i) wrap_ev |=> irq_stat_r[playback_pkg::EV_WRAP];
	endproperty
	a_wrap_irq: assert property (p_wrap_irq) else $error("wrap event not recorded"); // RQ1
	// the accumulator must stay below its top, or a 9-bit sum could overflow and lose a tick
	property p_phase;
		@(posedge clk_i) disable iff (!nrst_i) phase_r < playback_pkg::PHASE_TOP;
	endproperty
	a_phase: assert property (p_phase) else $error("phase accumulator out of range"); // RQ7

	// clocks since the previous tick or the start, for the spacing checks
	logic [4:0] gap_r;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			gap_r <= '0;
		end else if (tick | start_ok) begin
			gap_r <= 5'h01;
		end else begin
			gap_r <= gap_r + 5'h01;
		end
	end
	property p_rate12m5;
		@(posedge clk_i) disable iff (!nrst_i) tick & (rate_r == playback_pkg::RATE_12M5)
			|-> gap_r == 5'(playback_pkg::PHASE_TOP / playback_pkg::STEP_12M5);
	endproperty
	a_rate12m5: assert property (p_rate12m5) else $error("12.5 MHz spacing wrong"); // RQ2
	// 32 MHz is not a divisor of the clock, so spacing takes two lengths, three of 6 clocks to one of 7
	property p_rate32;
		@(posedge clk_i) disable iff (!nrst_i) tick & (rate_r == playback_pkg::RATE_32M)
			|-> (gap_r >= 5'(playback_pkg::PHASE_TOP / playback_pkg::STEP_32M))
			& (gap_r <= 5'(playback_pkg::PHASE_TOP / playback_pkg::STEP_32M + 9'h001));
	endproperty
	a_rate32: assert property (p_rate32) else $error("32 MHz spacing wrong"); // RQ2
endmodule // looped_waveform_playback

/* verif/dac_model.sv */
`timescale 1ns/10ps
// converter stand-in: records each update and the clocks since the previous one
module dac_model (
	input wire logic clk_i,
	input wire logic strobe_i,
	input wire logic [playback_pkg::CODE_W-1:0] code_i
);
	logic [playback_pkg::CODE_W-1:0] codes[$];
	int gaps[$];
	int since = 0;
	// the code is only trusted at a strobe, as a real converter latches it then
	always @(posedge clk_i) begin
		if (strobe_i === 1'b1) begin
			codes.push_back(code_i);
			gaps.push_back(since + 1);
			since <= 0;
		end else begin
			since <= since + 1;
		end
	end
endmodule // dac_model

/* verif/tb.sv */
`timescale 1ns/10ps
`define CHK(nm, e, s) begin num_checks++; if ((e) !== (s)) begin error_cnt++; \
	$display("[ERR] %s exp %0h got %0h", nm, (e), (s)); end end
// register-driven bench for the looped playback engine
module tb;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, strobe, running, irq;
	logic [13:0] code;
	// test tones, not noise, so the long-set minimum for noise does not apply
	logic [13:0] mem [3] = '{14'h0000, 14'h3FFF, 14'h2000};
	int error_cnt = 0;
	int num_checks = 0;
	int sum;
	int exp_sum [3] = '{25, 64, 8};

	looped_waveform_playback u_looped_waveform_playback (.clk_i(clk_i), .nrst_i(nrst_i),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.dac_code_o(code), .dac_strobe_o(strobe), .running_o(running), .irq_o(irq));
	dac_model u_dac_model (.clk_i(clk_i), .strobe_i(strobe), .code_i(code));

	initial begin
		forever #2.5 clk_i = ~clk_i;
	end

	// one transfer; the request holds until pready is seen high at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		do @(posedge clk_i); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// step off the edge so registered outputs have settled
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// whole run is near 660 clocks, so this only trips on a hang
	initial begin
		#100us;
		error_cnt++;
		finish_test();
	end

	initial begin
		repeat (6) @(posedge clk_i);
		nrst_i <= 1'b1;
		apb(1'b0, playback_pkg::STATUS_ADDR, 32'h0);
		`CHK("status", 32'h0, rd)
		apb(1'b0, 8'h24, 32'h0);
		`CHK("unmapped err", 1'b1, err)
		`CHK("unmapped data", 32'h0, rd)
		apb(1'b1, playback_pkg::LOAD_ADDR_ADDR, 32'h0);
		for (int i = 0; i < 3; i++) apb(1'b1, playback_pkg::LOAD_DATA_ADDR, 32'(mem[i]));
		apb(1'b1, playback_pkg::COUNT_ADDR, 32'h3);
		apb(1'b1, playback_pkg::IRQ_MASK_ADDR, 32'h4);
		// every rate; mid-run count and rate writes must change nothing
		for (int r = 0; r < 3; r++) begin
			u_dac_model.codes.delete();
			u_dac_model.gaps.delete();
			apb(1'b1, playback_pkg::CTRL_ADDR, 32'(r * 2 + 1));
			cyc(30);
			apb(1'b1, playback_pkg::COUNT_ADDR, 32'h1);
			apb(1'b1, playback_pkg::CTRL_ADDR, 32'(((r + 1) % 3) * 2 + 1));
			cyc(90);
			`CHK("running", 1'b1, running)
			apb(1'b1, playback_pkg::CTRL_ADDR, 32'h0);
			cyc(2);
			`CHK("stopped", 1'b0, running)
			sum = u_dac_model.codes.size();
			cyc(40);
			`CHK("no strobes", sum, u_dac_model.codes.size())
			for (int i = 0; i < 5; i++) `CHK("code", mem[i % 3], u_dac_model.codes[i])
			sum = 0;
			for (int i = 1; i < 5; i++) sum += u_dac_model.gaps[i];
			`CHK("spacing", exp_sum[r], sum)
			`CHK("wrap irq", 1'b1, irq)
			apb(1'b1, playback_pkg::IRQ_STAT_ADDR, 32'h4);
			cyc(1);
			`CHK("irq clear", 1'b0, irq)
		end
		apb(1'b1, playback_pkg::CTRL_ADDR, 32'h7);
		cyc(2);
		`CHK("bad rate", 1'b0, running)
		// out-of-range sample: set rejected and start refused
		apb(1'b1, playback_pkg::LOAD_ADDR_ADDR, 32'h0);
		apb(1'b1, playback_pkg::LOAD_DATA_ADDR, 32'h4000);
		apb(1'b0, playback_pkg::STATUS_ADDR, 32'h0);
		`CHK("rejected", 32'h2, rd)
		apb(1'b1, playback_pkg::CTRL_ADDR, 32'h1);
		cyc(2);
		`CHK("start on bad set", 1'b0, running)
		apb(1'b1, playback_pkg::IRQ_MASK_ADDR, 32'h3);
		cyc(1);
		`CHK("range irq", 1'b1, irq)
		apb(1'b1, playback_pkg::IRQ_STAT_ADDR, 32'h1);
		apb(1'b1, playback_pkg::COUNT_ADDR, 32'h3);
		// upper-half bits set also reject the set
		apb(1'b1, playback_pkg::LOAD_ADDR_ADDR, 32'h0);
		apb(1'b1, playback_pkg::LOAD_DATA_ADDR, 32'h00010000);
		apb(1'b0, playback_pkg::STATUS_ADDR, 32'h0);
		`CHK("rejected high", 32'h2, rd)
		apb(1'b1, playback_pkg::IRQ_STAT_ADDR, 32'h1);
		// count limits: one past the maximum ignored, the maximum taken, zero refuses start
		apb(1'b1, playback_pkg::COUNT_ADDR, 32'h01000001);
		apb(1'b0, playback_pkg::COUNT_ADDR, 32'h0);
		`CHK("count over max", 32'h3, rd)
		apb(1'b1, playback_pkg::COUNT_ADDR, 32'h01000000);
		apb(1'b0, playback_pkg::COUNT_ADDR, 32'h0);
		`CHK("count max", 32'h01000000, rd)
		apb(1'b1, playback_pkg::COUNT_ADDR, 32'h0);
		apb(1'b1, playback_pkg::CTRL_ADDR, 32'h1);
		cyc(2);
		`CHK("start on empty set", 1'b0, running)
		apb(1'b1, playback_pkg::COUNT_ADDR, 32'h3);
		// overload one step past the limit, then exactly at it
		apb(1'b1, playback_pkg::LEVEL_ADDR, 32'h190);
		apb(1'b1, playback_pkg::LOSS_ADDR, 32'h1);
		apb(1'b0, playback_pkg::STATUS_ADDR, 32'h0);
		`CHK("overload", 32'h4, rd)
		apb(1'b1, playback_pkg::CTRL_ADDR, 32'h1);
		cyc(2);
		`CHK("start on overload", 1'b0, running)
		apb(1'b0, playback_pkg::IRQ_STAT_ADDR, 32'h0);
		`CHK("overload event", 32'h2, rd)
		apb(1'b1, playback_pkg::LOSS_ADDR, 32'h0);
		apb(1'b1, playback_pkg::CTRL_ADDR, 32'h1);
		cyc(2);
		`CHK("start at limit", 1'b1, running)
		apb(1'b1, playback_pkg::CTRL_ADDR, 32'h0);
		finish_test();
	end
endmodule // tb
